// ===== sssp_device.sv
`timescale 1ns/1ps
// How it works
// - Eight-bit shift register, done after eight clocks
// - Load nibbles, write trigger to start sending
// - Master uses own clock, slave uses pin
// - Negative polarity: output changes on falling edge
// - Negative polarity shift edge follows phase bit
// - Positive polarity: output changes on rising edge
// - Positive polarity shift edge follows phase bit
// - Negative polarity capture edge follows phase bit
// - Positive polarity capture edge follows phase bit
// - Done flag always set; mask gates request
// - Received byte readable through nibble registers
// - Bit order selects LSB or MSB first
// - Software sets bit order before loading data
// - Ready pin asserted by slave trigger only
// - Negative ready: low on trigger, high on clock
// - Positive ready: high on trigger, low on clock
// - High nibble access drops ready
// - Master stops after eight pulses, clock idle
// - Slave ignores clocks after eight pulses
// - Trigger bit reads one while running
// - Order bit one is MSB first, resets zero
module sssp_device #(
	parameter bit POS_POL = 1'b0
) (
	// System
	input wire logic clk_sys,
	input wire logic reset_n,
	// CPU register port
	input wire logic [sssp_pkg::ADDR_W-1:0] cpu_addr,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [sssp_pkg::NIB_W-1:0] cpu_wdata,
	output logic [sssp_pkg::NIB_W-1:0] cpu_rdata,
	// Interrupt request
	output logic irq,
	// Serial link
	sssp_link_if.dev link
);
	import sssp_pkg::*;

	logic master_q; // Master mode select
	logic phase_q; // Clock phase select
	logic order_q; // Bit order select, 1 is MSB first
	logic mask_q; // Done interrupt mask
	logic flag_q; // Done flag
	logic irq_q; // Registered interrupt request
	logic rdy_q; // Ready active
	logic [3:0] rdata_q; // Registered read data
	logic [1:0] sy1_q; // First sync stage {clock, data}
	logic [1:0] sy2_q; // Second sync stage
	logic sin_d_q; // Data one cycle older, for slave capture
	logic nprev_q; // Previous normalised pin clock
	logic pin_n; // Normalised pin clock, idle high
	logic s_lead; // Slave leading edge
	logic s_trail; // Slave trailing edge
	logic gen_on_q; // Master clock generator running
	logic gen_n_q; // Generated clock, normalised
	logic [3:0] div_q; // Half-period divider
	logic [3:0] halves_q; // Half periods driven
	logic tick; // Half period expires
	logic m_lead; // Master leading edge
	logic m_trail; // Master trailing edge
	logic lead; // Selected leading edge
	logic trail; // Selected trailing edge
	logic wr_ctrl; // Trigger register write
	logic trig; // Transfer start
	logic wr_lo; // Low nibble write
	logic wr_hi; // High nibble write
	logic acc_hi; // High nibble read or write
	logic [7:0] sr; // Shift register contents
	logic serial_out_pin; // Serial output bit
	logic busy; // Transfer running
	logic done; // Transfer complete pulse
	logic [7:0] ld_data; // Merged nibble load

	// Register access decode
	assign wr_ctrl = cpu_wr && (cpu_addr == ADDR_CTRL);
	assign trig = wr_ctrl && cpu_wdata[TRIG_BIT];
	assign wr_lo = cpu_wr && (cpu_addr == ADDR_DLO);
	assign wr_hi = cpu_wr && (cpu_addr == ADDR_DHI);
	assign acc_hi = (cpu_wr || cpu_rd) && (cpu_addr == ADDR_DHI);
	// Nibble write keeps the other half
	assign ld_data = wr_hi ? {cpu_wdata, sr[3:0]} : {sr[7:4], cpu_wdata};

	// Mode register: master, phase, bit order
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			master_q <= MODE_RST[MASTER_BIT];
			phase_q <= MODE_RST[PHASE_BIT];
			order_q <= MODE_RST[ORDER_BIT];
		end else if (cpu_wr && (cpu_addr == ADDR_MODE)) begin
			master_q <= cpu_wdata[MASTER_BIT];
			phase_q <= cpu_wdata[PHASE_BIT];
			order_q <= cpu_wdata[ORDER_BIT];
		end
	end

	// Interrupt mask register
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) mask_q <= 1'b0;
		else if (cpu_wr && (cpu_addr == ADDR_MASK)) mask_q <= cpu_wdata[FLAG_BIT];
	end

	// Done flag: completion sets it, writing one clears; set wins
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) flag_q <= 1'b0;
		else if (done) flag_q <= 1'b1;
		else if (cpu_wr && (cpu_addr == ADDR_FLAG) && cpu_wdata[FLAG_BIT]) flag_q <= 1'b0;
	end

	// Request only when unmasked
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) irq_q <= 1'b0;
		else irq_q <= (flag_q || done) && mask_q;
	end
	assign irq = irq_q;

	// Two-stage synchroniser for clock and data pins
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sy1_q <= 2'b11;
			sy2_q <= 2'b11;
			sin_d_q <= 1'b1;
		end else begin
			sy1_q <= {link.sclk, link.par_serial_out_pin};
			sy2_q <= sy1_q;
			sin_d_q <= sy2_q[0];
		end
	end

	// Polarity folded so that idle is high
	assign pin_n = POS_POL ? ~sy2_q[1] : sy2_q[1];

	// Edge detector on the synchronised clock
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) nprev_q <= 1'b1;
		else nprev_q <= pin_n;
	end
	assign s_lead = nprev_q && !pin_n;
	assign s_trail = !nprev_q && pin_n;

	// Master clock generator: sixteen half periods then idle
	assign tick = gen_on_q && (div_q == 4'(DEV_HALF - 1));
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			gen_on_q <= 1'b0;
			gen_n_q <= 1'b1;
			div_q <= 4'h0;
			halves_q <= 4'h0;
		end else if (trig && master_q) begin
			gen_on_q <= 1'b1;
			gen_n_q <= 1'b1;
			div_q <= 4'h0;
			halves_q <= 4'h0;
		end else if (tick) begin
			div_q <= 4'h0;
			gen_n_q <= ~gen_n_q;
			halves_q <= halves_q + 4'h1;
			if (halves_q == HALVES_LAST) gen_on_q <= 1'b0;
		end else if (gen_on_q) begin
			div_q <= div_q + 4'h1;
		end
	end
	assign m_lead = tick && gen_n_q;
	assign m_trail = tick && !gen_n_q;

	// Clock source by mode
	assign lead = master_q ? m_lead : s_lead;
	assign trail = master_q ? m_trail : s_trail;

	// Shift engine; counts eight captures then ignores edges
	sssp_shift_core u_core (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.start(trig),
		.load(wr_lo || wr_hi),
		.load_data(ld_data),
		.phase(phase_q),
		.msb_first(order_q),
		.lead(lead),
		.trail(trail),
		// Slave takes data as it stood before the edge; both cross together
		.serial_in_pin(master_q ? sy2_q[0] : sin_d_q),
		.data(sr),
		.serial_out_pin(serial_out_pin),
		.busy(busy),
		.done(done)
	);

	// Ready: set on slave trigger, dropped by clock or high nibble access
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) rdy_q <= 1'b0;
		else if (trig && !master_q) rdy_q <= 1'b1;
		else if (acc_hi) rdy_q <= 1'b0;
		else if (s_lead) rdy_q <= 1'b0;
	end

	// Pins; output enable low while driving
	assign link.dev_sclk_o = POS_POL ? ~gen_n_q : gen_n_q;
	assign link.dev_sclk_oe_n = ~master_q;
	assign link.dev_serial_out_pin = serial_out_pin;
	assign link.dev_rdy = POS_POL ? rdy_q : ~rdy_q;

	// Registered read data
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) rdata_q <= 4'h0;
		else if (cpu_rd) begin
			case (cpu_addr)
				ADDR_CTRL: rdata_q <= {2'b00, busy, 1'b0};
				ADDR_MODE: rdata_q <= {order_q, phase_q, 1'b0, master_q};
				ADDR_DLO: rdata_q <= sr[3:0];
				ADDR_DHI: rdata_q <= sr[7:4];
				ADDR_MASK: rdata_q <= {3'b000, mask_q};
				ADDR_FLAG: rdata_q <= {3'b000, flag_q};
				default: rdata_q <= 4'h0;
			endcase
		end
	end
	assign cpu_rdata = rdata_q;
endmodule

// ===== sssp_pkg.sv
package sssp_pkg;
	// Device register addresses (nibble-wide CPU port)
	localparam logic [15:0] ADDR_CTRL = 16'hff70;
	localparam logic [15:0] ADDR_MODE = 16'hff71;
	localparam logic [15:0] ADDR_DLO = 16'hff72;
	localparam logic [15:0] ADDR_DHI = 16'hff73;
	localparam logic [15:0] ADDR_MASK = 16'hffe3;
	localparam logic [15:0] ADDR_FLAG = 16'hfff3;
	localparam int ADDR_W = 16;
	localparam int NIB_W = 4;
	// Bit positions in the device registers
	localparam int TRIG_BIT = 1;
	localparam int MASTER_BIT = 0;
	localparam int PHASE_BIT = 2;
	localparam int ORDER_BIT = 3;
	localparam int FLAG_BIT = 0;
	// Reset values
	localparam logic [3:0] MODE_RST = 4'h0;
	localparam logic [7:0] DATA_RST = 8'h00;
	// Transfer length
	localparam int BITS = 8;
	localparam logic [2:0] LAST_BIT = 3'h7;
	// Timing: system clock and serial clock periods in ns
	localparam int CLK_NS = 10;
	// Device half period must cover the far end's sync and answer delay
	localparam int DEV_SCLK_NS = 120;
	localparam int PAR_SCLK_NS = 125;
	localparam int DEV_HALF = (DEV_SCLK_NS / 2) / CLK_NS;
	localparam int PAR_HALF = (PAR_SCLK_NS / 2) / CLK_NS;
	localparam logic [3:0] HALVES_LAST = 4'hf;
	// Partner AXI4-Lite register offsets and fields
	localparam logic [3:0] P_CTRL = 4'h0;
	localparam logic [3:0] P_TX = 4'h4;
	localparam logic [3:0] P_RX = 4'h8;
	localparam logic [3:0] P_STAT = 4'hc;
	localparam int P_START_BIT = 0;
	localparam int P_BUSY_BIT = 0;
	localparam int P_RDY_BIT = 1;
	localparam int P_DONE_BIT = 2;
	localparam logic [1:0] RESP_OK = 2'b00;
	localparam logic [1:0] RESP_ERR = 2'b10;
	// Shift engine states
	typedef enum logic {SSSP_IDLE, SSSP_SHIFT} sssp_state_t;
endpackage

// ===== sssp_link_if.sv
`timescale 1ns/1ps
interface sssp_link_if;
	logic dev_sclk_o; // Device clock drive
	logic dev_sclk_oe_n; // Low while device drives clock
	logic par_sclk_o; // Partner clock drive
	logic par_sclk_oe_n; // Low while partner drives clock
	logic sclk; // Resolved clock wire
	logic dev_serial_out_pin; // Device data out to partner
	logic par_serial_out_pin; // Partner data out to device
	logic dev_rdy; // Slave ready from device
	// Wire level from enables; pulled up when undriven
	assign sclk = !dev_sclk_oe_n ? dev_sclk_o : (!par_sclk_oe_n ? par_sclk_o : 1'b1);
	modport dev (output dev_sclk_o, output dev_sclk_oe_n, output dev_serial_out_pin, output dev_rdy,
		input sclk, input par_serial_out_pin);
	modport par (output par_sclk_o, output par_sclk_oe_n, output par_serial_out_pin,
		input sclk, input dev_serial_out_pin, input dev_rdy);
endinterface

// ===== sssp_shift_core.sv
`timescale 1ns/1ps
module sssp_shift_core (
	// System
	input wire logic clk_sys,
	input wire logic reset_n,
	// Control
	input wire logic start,
	input wire logic load,
	input wire logic [7:0] load_data,
	input wire logic phase,
	input wire logic msb_first,
	// Normalised clock edges and serial input
	input wire logic lead,
	input wire logic trail,
	input wire logic serial_in_pin,
	// Status and data
	output logic [7:0] data,
	output logic serial_out_pin,
	output logic busy,
	output logic done
);
	import sssp_pkg::*;
	sssp_state_t state_q; // Idle or shifting
	logic [2:0] cnt_q; // Captured bits so far
	logic cap; // Capture edge this cycle
	assign cap = (state_q == SSSP_SHIFT) && (phase ? lead : trail);
	assign busy = (state_q == SSSP_SHIFT);
	// Bit that leaves first in the chosen order
	function automatic logic first_bit(input logic [7:0] v, input logic msb);
		first_bit = msb ? v[7] : v[0];
	endfunction
	// Sequencer; edges outside a transfer are ignored
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= SSSP_IDLE;
			cnt_q <= 3'h0;
		end else if (start) begin
			// A trigger always restarts the count
			state_q <= SSSP_SHIFT;
			cnt_q <= 3'h0;
		end else begin
			case (state_q)
				SSSP_IDLE: cnt_q <= 3'h0;
				SSSP_SHIFT: begin
					if (cap) begin
						cnt_q <= cnt_q + 3'h1;
						if (cnt_q == LAST_BIT) state_q <= SSSP_IDLE;
					end
				end
				default: state_q <= SSSP_IDLE;
			endcase
		end
	end
	// Shift register: capture shifts in the new bit
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) data <= DATA_RST;
		else if (cap) data <= msb_first ? {data[6:0], serial_in_pin} : {serial_in_pin, data[7:1]};
		else if (load) data <= load_data;
	end
	// Output bit moves on the leading edge; with phase one the first bit
	// stands before the clock starts and each shift shows the next bit
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) serial_out_pin <= 1'b1;
		else if (busy && lead && phase) serial_out_pin <= msb_first ? data[6] : data[1];
		else if (busy && lead) serial_out_pin <= first_bit(data, msb_first);
		else if (phase && (cnt_q == 3'h0)) serial_out_pin <= first_bit(data, msb_first);
	end
	// One-cycle pulse on the eighth capture
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) done <= 1'b0;
		else done <= cap && (cnt_q == LAST_BIT);
	end
endmodule

// ===== sssp_partner.sv
`timescale 1ns/1ps
module sssp_partner #(
	parameter bit POS_POL = 1'b0
) (
	// System
	input wire logic clk_sys,
	input wire logic reset_n,
	// AXI4-Lite write channels
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Serial link
	sssp_link_if.par link
);
	import sssp_pkg::*;

	logic master_q, phase_q, order_q; // Control fields
	logic done_q; // Sticky done
	logic [2:0] sy1_q, sy2_q; // Sync {clock, data, ready}
	logic nprev_q; // Previous normalised clock
	logic pin_n, s_lead, s_trail; // Slave edges
	logic gen_on_q, gen_n_q, tick; // Clock generator
	logic [3:0] div_q, halves_q;
	logic wtake, wr_en, start, busy, done, serial_out_pin;
	logic [7:0] rx;
	logic sin_d_q; // Data one cycle older, for slave capture

	// Write: both channels taken together, one cycle ready
	assign wtake = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
	assign wr_en = wtake && s_axi_wstrb[0];
	assign start = wr_en && (s_axi_awaddr == P_CTRL) && s_axi_wdata[P_START_BIT];
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OK;
		end else begin
			s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			if (wtake) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (s_axi_awaddr[1:0] == 2'b00) ? RESP_OK : RESP_ERR;
			end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
		end
	end

	// Control register
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) {order_q, phase_q, master_q} <= 3'b000;
		else if (wr_en && (s_axi_awaddr == P_CTRL)) {order_q, phase_q, master_q} <= s_axi_wdata[3:1];
	end

	// Sticky done; set wins over write-one clear
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) done_q <= 1'b0;
		else if (done) done_q <= 1'b1;
		else if (wr_en && (s_axi_awaddr == P_STAT) && s_axi_wdata[P_DONE_BIT]) done_q <= 1'b0;
	end

	// Read: one-cycle ready, data the cycle after
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OK;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arready && s_axi_arvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OK;
				case (s_axi_araddr)
					P_CTRL: s_axi_rdata <= {28'h0, order_q, phase_q, master_q, 1'b0};
					P_RX: s_axi_rdata <= {24'h0, rx};
					P_STAT: s_axi_rdata <= {29'h0, done_q, POS_POL ? sy2_q[0] : ~sy2_q[0], busy};
					P_TX: s_axi_rdata <= {24'h0, rx};
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= RESP_ERR;
					end
				endcase
			end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
		end
	end

	// Synchronise clock, data and ready pins
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sy1_q <= 3'b111;
			sy2_q <= 3'b111;
			sin_d_q <= 1'b1;
		end else begin
			sy1_q <= {link.sclk, link.dev_serial_out_pin, link.dev_rdy};
			sy2_q <= sy1_q;
			sin_d_q <= sy2_q[1];
		end
	end
	assign pin_n = POS_POL ? ~sy2_q[2] : sy2_q[2];
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) nprev_q <= 1'b1;
		else nprev_q <= pin_n;
	end
	assign s_lead = nprev_q && !pin_n;
	assign s_trail = !nprev_q && pin_n;

	// Master clock: eight periods from own divider
	assign tick = gen_on_q && (div_q == 4'(PAR_HALF - 1));
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			gen_on_q <= 1'b0;
			gen_n_q <= 1'b1;
			div_q <= 4'h0;
			halves_q <= 4'h0;
		end else if (start && s_axi_wdata[1]) begin
			gen_on_q <= 1'b1;
			div_q <= 4'h0;
			halves_q <= 4'h0;
		end else if (tick) begin
			div_q <= 4'h0;
			gen_n_q <= ~gen_n_q;
			halves_q <= halves_q + 4'h1;
			if (halves_q == HALVES_LAST) gen_on_q <= 1'b0;
		end else if (gen_on_q) div_q <= div_q + 4'h1;
	end

	sssp_shift_core u_core (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.start(start),
		.load(wr_en && (s_axi_awaddr == P_TX)),
		.load_data(s_axi_wdata[7:0]),
		.phase(phase_q),
		.msb_first(order_q),
		.lead(master_q ? (tick && gen_n_q) : s_lead),
		.trail(master_q ? (tick && !gen_n_q) : s_trail),
		.serial_in_pin(master_q ? sy2_q[1] : sin_d_q),
		.data(rx),
		.serial_out_pin(serial_out_pin),
		.busy(busy),
		.done(done)
	);

	// Pins; clock driven only as master
	assign link.par_sclk_o = POS_POL ? ~gen_n_q : gen_n_q;
	assign link.par_sclk_oe_n = ~master_q;
	assign link.par_serial_out_pin = serial_out_pin;
endmodule

// ===== sssp_link_monitor.sv
`timescale 1ns/1ps
module sssp_link_monitor #(
	parameter bit POS_POL = 1'b0
) (
	// System
	input wire logic clk_sys,
	input wire logic reset_n,
	// Clock wires
	input wire logic dev_sclk_o,
	input wire logic dev_sclk_oe_n,
	input wire logic par_sclk_o,
	input wire logic par_sclk_oe_n,
	input wire logic sclk,
	// Data and ready wires
	input wire logic dev_serial_out_pin,
	input wire logic par_serial_out_pin,
	input wire logic dev_rdy
);
	localparam logic IDLE = !POS_POL; // Clock idle level
	localparam logic RDY_ON = POS_POL; // Ready active level
	logic sclk_q; // Wire clock one cycle ago
	logic dev_ck_q; // Device clock drive one cycle ago
	logic [3:0] since_lead_q; // Cycles since leading edge, saturates
	logic [3:0] still_q; // Cycles device drive unchanged
	logic [3:0] pulses_q; // Device pulses in this burst
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// Age of the last leading edge on the wire
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sclk_q <= IDLE;
			since_lead_q <= 4'hf;
		end else begin
			sclk_q <= sclk;
			if (sclk != IDLE && sclk_q == IDLE) begin
				since_lead_q <= 4'h0;
			end else if (since_lead_q != 4'hf) begin
				since_lead_q <= since_lead_q + 4'h1;
			end
		end
	end
	// Pulse count of each device clock burst
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			dev_ck_q <= IDLE;
			still_q <= 4'h0;
			pulses_q <= 4'h0;
		end else begin
			dev_ck_q <= dev_sclk_o;
			if (dev_sclk_o != dev_ck_q) begin
				still_q <= 4'h0;
			end else if (still_q != 4'hf) begin
				still_q <= still_q + 4'h1;
			end
			if (dev_sclk_o != IDLE && dev_ck_q == IDLE && !dev_sclk_oe_n) begin
				pulses_q <= pulses_q + 4'h1;
			end else if (still_q == 4'hd) begin
				pulses_q <= 4'h0;
			end
		end
	end
	// Clock held at its active level for a whole partner half period
	sequence s_clk_held;
		(sclk != IDLE)[*6];
	endsequence
	property p_dev_serial_out_pin_lead;
		$changed(dev_serial_out_pin) && since_lead_q != 4'hf |->
			since_lead_q <= 4'h6 || (sclk != IDLE && sclk_q == IDLE);
	endproperty
	a_dev_serial_out_pin_lead: assert property (p_dev_serial_out_pin_lead)
		else $error("device data moved away from a leading edge");
	property p_par_serial_out_pin_lead;
		$changed(par_serial_out_pin) && since_lead_q != 4'hf |->
			since_lead_q <= 4'h6 || (sclk != IDLE && sclk_q == IDLE);
	endproperty
	a_par_serial_out_pin_lead: assert property (p_par_serial_out_pin_lead)
		else $error("partner data moved away from a leading edge");
	property p_dev_half;
		$changed(dev_sclk_o) && !dev_sclk_oe_n |=> $stable(dev_sclk_o)[*5];
	endproperty
	a_dev_half: assert property (p_dev_half)
		else $error("device clock half period too short");
	property p_par_half;
		$changed(par_sclk_o) && !par_sclk_oe_n |=> $stable(par_sclk_o)[*5];
	endproperty
	a_par_half: assert property (p_par_half)
		else $error("partner clock half period too short");
	property p_dev_pulses;
		still_q == 4'hc |-> pulses_q == 4'h0 || pulses_q == 4'h8;
	endproperty
	a_dev_pulses: assert property (p_dev_pulses)
		else $error("device clock burst not eight pulses");
	property p_dev_idle;
		still_q == 4'hc && !dev_sclk_oe_n |-> dev_sclk_o == IDLE;
	endproperty
	a_dev_idle: assert property (p_dev_idle)
		else $error("device clock stopped at the active level");
	property p_rdy_master;
		!dev_sclk_oe_n |-> dev_rdy != RDY_ON;
	endproperty
	a_rdy_master: assert property (p_rdy_master)
		else $error("ready active in master mode");
	property p_rdy_drop;
		s_clk_held |-> dev_rdy != RDY_ON;
	endproperty
	a_rdy_drop: assert property (p_rdy_drop)
		else $error("ready still active after clock started");
	property p_rdy_rise;
		$changed(dev_rdy) && dev_rdy == RDY_ON |-> since_lead_q == 4'hf;
	endproperty
	a_rdy_rise: assert property (p_rdy_rise)
		else $error("ready raised during a burst");
endmodule

// ===== tb_sync_serial_shift_port.sv
`timescale 1ns/1ps
module tb_sync_serial_shift_port;
	import sssp_pkg::*;
	localparam bit POS_POL = 1'b0; // Negative polarity build
	logic clk_sys, reset_n, cpu_wr, cpu_rd, irq, sclk_q, mask_on;
	logic [15:0] cpu_addr;
	logic [3:0] cpu_wdata, cpu_rdata, s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] wire_dev, wire_par; // Bits seen on the data lines
	int n_fail, cmp_count;
	sssp_link_if lnk ();
	sssp_device #(.POS_POL(POS_POL)) sssp_device_i (.clk_sys, .reset_n, .cpu_addr, .cpu_wr,
		.cpu_rd, .cpu_wdata, .cpu_rdata, .irq, .link(lnk));
	sssp_partner #(.POS_POL(POS_POL)) sssp_partner_i (.clk_sys, .reset_n, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .link(lnk));
	sssp_link_monitor #(.POS_POL(POS_POL)) sssp_link_monitor_i (.clk_sys, .reset_n,
		.dev_sclk_o(lnk.dev_sclk_o), .dev_sclk_oe_n(lnk.dev_sclk_oe_n),
		.par_sclk_o(lnk.par_sclk_o), .par_sclk_oe_n(lnk.par_sclk_oe_n), .sclk(lnk.sclk),
		.dev_serial_out_pin(lnk.dev_serial_out_pin), .par_serial_out_pin(lnk.par_serial_out_pin), .dev_rdy(lnk.dev_rdy));
	// System clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Shift in both data lines at each trailing clock edge
	always @(posedge clk_sys) begin
		sclk_q <= lnk.sclk;
		if (lnk.sclk == !POS_POL && sclk_q == POS_POL) begin
			wire_dev <= {wire_dev[6:0], lnk.dev_serial_out_pin};
			wire_par <= {wire_par[6:0], lnk.par_serial_out_pin};
		end
	end
	function automatic logic [7:0] rev8(input logic [7:0] v);
		for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask
	task summarize;
		$display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task hang;
		$display("wait limit reached at %0t", $time);
		n_fail++;
		summarize();
	endtask
	// One-cycle strobes on the nibble port
	task cpu_w(input logic [15:0] a, input logic [3:0] d);
		@(posedge clk_sys);
		cpu_addr <= a;
		cpu_wdata <= d;
		cpu_wr <= 1'b1;
		@(posedge clk_sys);
		cpu_wr <= 1'b0;
	endtask
	task cpu_r(input logic [15:0] a, output logic [3:0] d);
		@(posedge clk_sys);
		cpu_addr <= a;
		cpu_rd <= 1'b1;
		@(posedge clk_sys);
		cpu_rd <= 1'b0;
		@(posedge clk_sys);
		d = cpu_rdata;
	endtask
	// Register cycles towards the partner end
	task axi_w(input logic [3:0] a, input logic [7:0] d);
		int n;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {24'h0, d};
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 64);
		chk(s_axi_bresp, RESP_OK);
		s_axi_bready <= 1'b0;
		if (n >= 64) hang();
	endtask
	task axi_r(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 64);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 64) hang();
	endtask
	// Full-duplex byte exchange; dm picks which end makes the clock
	task xfer(input bit dm, input bit ph, input bit msb, input logic [7:0] db,
		input logic [7:0] pb);
		logic [3:0] lo, hi;
		logic [31:0] pd;
		logic [1:0] rs;
		int n;
		cpu_w(ADDR_MODE, {msb, ph, 1'b0, dm});
		cpu_w(ADDR_DLO, db[3:0]);
		cpu_w(ADDR_DHI, db[7:4]);
		axi_w(P_TX, pb);
		if (dm) axi_w(P_CTRL, {4'h0, msb, ph, 2'b01});
		cpu_w(ADDR_CTRL, 4'h2);
		if (!dm) begin
			@(posedge clk_sys);
			#1 chk(lnk.dev_rdy, POS_POL);
			axi_w(P_CTRL, {4'h0, msb, ph, 2'b11});
		end
		cpu_r(ADDR_CTRL, lo);
		chk(lo[TRIG_BIT], 1'b1);
		for (n = 0; n < 100; n++) begin
			cpu_r(ADDR_CTRL, lo);
			axi_r(P_STAT, pd, rs);
			if (!lo[TRIG_BIT] && !pd[P_BUSY_BIT]) break;
		end
		if (n == 100) hang();
		chk(lnk.dev_rdy, !POS_POL);
		chk(lnk.sclk, !POS_POL);
		if (!ph) chk(wire_dev, msb ? db : rev8(db));
		if (!ph) chk(wire_par, msb ? pb : rev8(pb));
		cpu_r(ADDR_DLO, lo);
		cpu_r(ADDR_DHI, hi);
		chk({hi, lo}, pb);
		axi_r(P_RX, pd, rs);
		chk(pd, {24'h0, db});
		cpu_r(ADDR_FLAG, lo);
		chk(lo[FLAG_BIT], 1'b1);
		chk(irq, mask_on);
		cpu_w(ADDR_FLAG, 4'h1);
		repeat (2) @(posedge clk_sys);
		chk(irq, 1'b0);
		$display("transfer test done: master %0d phase %0d msb %0d", dm, ph, msb);
	endtask
	// Watchdog against a hung run
	initial begin
		#500000;
		hang();
	end
	// Main sequence
	initial begin
		logic [3:0] v;
		logic [31:0] d;
		logic [1:0] rs;
		reset_n = 1'b0;
		cpu_addr = 16'h0000;
		cpu_wr = 1'b0;
		cpu_rd = 1'b0;
		cpu_wdata = 4'h0;
		s_axi_awaddr = 4'h0;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 4'h0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		mask_on = 1'b0;
		n_fail = 0;
		cmp_count = 0;
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		cpu_r(ADDR_MODE, v);
		chk(v, MODE_RST);
		cpu_r(16'hff74, v);
		chk(v, 4'h0);
		axi_r(4'h2, d, rs);
		chk(rs, RESP_ERR);
		$display("reset test done");
		cpu_w(ADDR_CTRL, 4'h2);
		@(posedge clk_sys);
		#1 chk(lnk.dev_rdy, POS_POL);
		cpu_r(ADDR_DHI, v);
		#1 chk(lnk.dev_rdy, !POS_POL);
		$display("ready test done");
		xfer(1'b0, 1'b0, 1'b0, 8'h1e, 8'hc6);
		cpu_w(ADDR_MASK, 4'h1);
		mask_on = 1'b1;
		xfer(1'b1, 1'b0, 1'b1, 8'ha5, 8'h3c);
		xfer(1'b0, 1'b1, 1'b1, 8'h69, 8'h2b);
		xfer(1'b1, 1'b1, 1'b0, 8'hf0, 8'h17);
		summarize();
	end
endmodule
